// *** awd_pkg.sv ***
package awd_pkg;
  localparam logic [7:0] AWD_ADDR_RESULT = 8'hBF;
  localparam logic [7:0] AWD_ADDR_LOWER = 8'hC7;
  localparam logic [7:0] AWD_ADDR_UPPER = 8'hC5;
  localparam logic [7:0] AWD_ADDR_CTRL = 8'hE8;
  localparam logic [7:0] AWD_RESULT_RST = 8'h00;
  localparam logic [7:0] AWD_LOWER_RST = 8'h00;
  localparam logic [7:0] AWD_UPPER_RST = 8'h00;
  localparam logic [7:0] AWD_CTRL_RST = 8'h00;
  localparam logic AWD_FLAG_RST = 1'b0;
  localparam logic [7:0] AWD_RDATA_RST = 8'h00;
  localparam logic [7:0] AWD_UNMAPPED_RDATA = 8'h00;
  localparam int AWD_FLAG_BIT = 2;
endpackage : awd_pkg

// *** awd_cmp_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface awd_cmp_if #(
  parameter int WIDTH = 8
);
  logic [WIDTH-1:0] sample;
  logic [WIDTH-1:0] upper;
  logic [WIDTH-1:0] lower;
  logic sample_valid;
  logic out_of_band;
  modport owner (output sample, output upper, output lower, output sample_valid,
    input out_of_band);
  modport cmp (input sample, input upper, input lower, input sample_valid,
    output out_of_band);
endinterface : awd_cmp_if
`default_nettype wire

// *** awd_compare.sv ***
`timescale 1ns/1ps
`default_nettype none
module awd_compare (
  awd_cmp_if.cmp bus
);
  wire above_upper;
  wire below_lower;

  // Strict compares: a result equal to a limit is still inside the band.
  assign above_upper = bus.sample > bus.upper;
  assign below_lower = bus.sample < bus.lower;
  assign bus.out_of_band = bus.sample_valid && (above_upper || below_lower);
endmodule : awd_compare
`default_nettype wire

// *** awd_window_detector.sv ***
// Behaviour
// - Every new converter result is compared with both limits without software action.
// - A result outside the band raises the window compare flag.
// - The flag sits in the control register and drives the interrupt output.
// - Limits come from writable upper and lower limit registers.
// - Result byte readable at 0xBF, bits 7 to 0, reset zero.
// - Lower limit byte is read/write at 0xC7, reset zero.
`timescale 1ns/1ps
`default_nettype none
module awd_window_detector
  import awd_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_conv_done,
  input wire logic [7:0] i_conv_data,
  output logic o_window_flag
);
  function automatic logic sel(input logic [7:0] addr, input logic [7:0] reg_addr);
    sel = (addr == reg_addr);
  endfunction : sel

  logic [7:0] conversion_result_byte;
  logic [7:0] window_lower_limit;
  logic [7:0] window_upper_limit;
  logic [7:0] ctrl_bits;
  logic window_compare_flag;
  logic [7:0] next_rdata;

  wire wr_result;
  wire wr_lower;
  wire wr_upper;
  wire wr_ctrl;
  wire flag_clear;
  wire [7:0] converter_control_reg;
  wire addr_mapped;
  wire chk_out_of_band;

  awd_cmp_if #(.WIDTH(8)) cmp_bus ();

  assign wr_result = i_sfr_wr && sel(i_sfr_addr, AWD_ADDR_RESULT);
  assign wr_lower = i_sfr_wr && sel(i_sfr_addr, AWD_ADDR_LOWER);
  assign wr_upper = i_sfr_wr && sel(i_sfr_addr, AWD_ADDR_UPPER);
  assign wr_ctrl = i_sfr_wr && sel(i_sfr_addr, AWD_ADDR_CTRL);
  // Writing a one to the flag leaves it alone so a read-modify-write cannot fake an event.
  assign flag_clear = wr_ctrl && !i_sfr_wdata[AWD_FLAG_BIT];

  // The fresh converter word is compared as it arrives, so the flag lands with the result.
  assign cmp_bus.sample = i_conv_data;
  assign cmp_bus.sample_valid = i_conv_done;
  assign cmp_bus.upper = window_upper_limit;
  assign cmp_bus.lower = window_lower_limit;

  awd_compare u_compare (
    .bus(cmp_bus)
  );

  logic [7:0] converter_control_reg_tmp;
  always_comb
  begin
    converter_control_reg_tmp = ctrl_bits;
    converter_control_reg_tmp[AWD_FLAG_BIT] = window_compare_flag;
  end
  assign converter_control_reg = converter_control_reg_tmp;

  assign next_rdata = sel(i_sfr_addr, AWD_ADDR_RESULT) ? conversion_result_byte :
                      sel(i_sfr_addr, AWD_ADDR_LOWER) ? window_lower_limit :
                      sel(i_sfr_addr, AWD_ADDR_UPPER) ? window_upper_limit :
                      sel(i_sfr_addr, AWD_ADDR_CTRL) ? converter_control_reg :
                      AWD_UNMAPPED_RDATA;

  // A conversion that lands in the same cycle as a software write to the result wins.
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      conversion_result_byte <= AWD_RESULT_RST;
    else if (i_conv_done)
      conversion_result_byte <= i_conv_data;
    else if (wr_result)
      conversion_result_byte <= i_sfr_wdata;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      window_lower_limit <= AWD_LOWER_RST;
      window_upper_limit <= AWD_UPPER_RST;
      ctrl_bits <= AWD_CTRL_RST;
    end
    else
    begin
      if (wr_lower)
        window_lower_limit <= i_sfr_wdata;
      if (wr_upper)
        window_upper_limit <= i_sfr_wdata;
      if (wr_ctrl)
        ctrl_bits <= i_sfr_wdata;
    end
  end

  // Set beats clear so an out-of-band result in the clearing cycle is never lost.
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      window_compare_flag <= AWD_FLAG_RST;
    else if (cmp_bus.out_of_band)
      window_compare_flag <= 1'b1;
    else if (flag_clear)
      window_compare_flag <= 1'b0;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      o_sfr_rdata <= AWD_RDATA_RST;
    else if (i_sfr_rd)
      o_sfr_rdata <= next_rdata;
  end

  assign o_window_flag = window_compare_flag;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  // A second band test kept apart from the comparator, so a slip there cannot hide itself.
  assign chk_out_of_band = i_conv_done &&
    ((i_conv_data > window_upper_limit) || (i_conv_data < window_lower_limit));
  assign addr_mapped = sel(i_sfr_addr, AWD_ADDR_RESULT) || sel(i_sfr_addr, AWD_ADDR_LOWER) ||
    sel(i_sfr_addr, AWD_ADDR_UPPER) || sel(i_sfr_addr, AWD_ADDR_CTRL);

  sequence s_out_of_band;
    chk_out_of_band;
  endsequence

  sequence s_quiet_no_clear;
    !window_compare_flag && !chk_out_of_band;
  endsequence

  sequence s_lower_write_read;
    wr_lower ##1 !wr_lower ##1 (i_sfr_rd && sel(i_sfr_addr, AWD_ADDR_LOWER));
  endsequence

  sequence s_clear_with_event;
    flag_clear && chk_out_of_band;
  endsequence

  sequence s_write_one_idle;
    !window_compare_flag && wr_ctrl && i_sfr_wdata[AWD_FLAG_BIT] && !chk_out_of_band;
  endsequence

  AST_COMPARE_SETS_FLAG: assert property (s_out_of_band |=> o_window_flag)
    else $error("Out-of-band result did not raise the flag.");

  AST_NO_SPURIOUS_FLAG: assert property (s_quiet_no_clear |=> !o_window_flag)
    else $error("Flag rose without an out-of-band result.");

  AST_FLAG_STICKY: assert property (o_window_flag && !flag_clear |=> o_window_flag)
    else $error("Flag dropped without a software clear.");

  AST_FLAG_CLEARS: assert property (flag_clear && !chk_out_of_band
    |=> !o_window_flag)
    else $error("Software clear did not drop the flag.");

  AST_SET_BEATS_CLEAR: assert property (s_clear_with_event |=> o_window_flag)
    else $error("A clear in the event cycle lost the flag.");

  AST_WRITE_ONE_NO_SET: assert property (s_write_one_idle |=> !o_window_flag)
    else $error("Writing one to the flag bit raised the flag.");

  AST_RESULT_LOADS: assert property (i_conv_done
    |=> conversion_result_byte == $past(i_conv_data))
    else $error("Result byte did not take the converter word.");

  AST_RESULT_WRITE: assert property (wr_result && !i_conv_done
    |=> conversion_result_byte == $past(i_sfr_wdata))
    else $error("Result byte did not take the written byte.");

  AST_RESULT_HOLDS: assert property (!i_conv_done && !wr_result
    |=> $stable(conversion_result_byte))
    else $error("Result byte changed with no conversion or write.");

  AST_RESULT_READ: assert property (i_sfr_rd && sel(i_sfr_addr, AWD_ADDR_RESULT)
    |=> o_sfr_rdata == $past(conversion_result_byte))
    else $error("Result read returned the wrong byte.");

  AST_LOWER_WRITE: assert property (wr_lower
    |=> window_lower_limit == $past(i_sfr_wdata))
    else $error("Lower limit did not take the written byte.");

  AST_LOWER_HOLDS: assert property (!wr_lower |=> $stable(window_lower_limit))
    else $error("Lower limit changed without a write.");

  AST_LOWER_READ: assert property (i_sfr_rd && sel(i_sfr_addr, AWD_ADDR_LOWER)
    |=> o_sfr_rdata == $past(window_lower_limit))
    else $error("Lower limit read returned the wrong byte.");

  AST_LOWER_RW: assert property (s_lower_write_read
    |=> o_sfr_rdata == $past(i_sfr_wdata, 3))
    else $error("Lower limit did not read back what was written.");

  AST_UPPER_WRITE: assert property (wr_upper
    |=> window_upper_limit == $past(i_sfr_wdata))
    else $error("Upper limit did not take the written byte.");

  AST_UPPER_HOLDS: assert property (!wr_upper |=> $stable(window_upper_limit))
    else $error("Upper limit changed without a write.");

  AST_UPPER_READ: assert property (i_sfr_rd && sel(i_sfr_addr, AWD_ADDR_UPPER)
    |=> o_sfr_rdata == $past(window_upper_limit))
    else $error("Upper limit read returned the wrong byte.");

  AST_CTRL_STORE: assert property (wr_ctrl |=> ctrl_bits == $past(i_sfr_wdata))
    else $error("Control storage did not take the written byte.");

  AST_FLAG_IN_CTRL: assert property (i_sfr_rd && sel(i_sfr_addr, AWD_ADDR_CTRL)
    |=> o_sfr_rdata[AWD_FLAG_BIT] == $past(o_window_flag))
    else $error("Control read does not show the flag.");

  AST_UNMAPPED_READ: assert property (i_sfr_rd && !addr_mapped
    |=> o_sfr_rdata == AWD_UNMAPPED_RDATA)
    else $error("Unmapped read did not return zero.");

  AST_RDATA_HOLDS: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata))
    else $error("Read data changed without a read.");
endmodule : awd_window_detector
`default_nettype wire

// *** awd_conv_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module awd_conv_model (
  input wire logic i_sys_clk,
  input wire logic i_go,
  input wire logic [7:0] i_val,
  output logic o_conv_done,
  output logic [7:0] o_conv_data
);
  // Data is inverted outside a result pulse, so a stale byte is never taken for a result.
  always @(negedge i_sys_clk)
  begin
    o_conv_done <= i_go;
    o_conv_data <= i_go ? i_val : ~o_conv_data;
  end
endmodule : awd_conv_model
`default_nettype wire

// *** awd_window_detector_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module awd_window_detector_bench;
  import awd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic go = 1'b0;
  logic [7:0] val = 8'h00;
  logic done;
  logic [7:0] data;
  logic flag;
  logic e;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int seed = 20264;
  logic [7:0] u, l, d, t;
  logic [7:0] amap [5] = '{AWD_ADDR_RESULT, AWD_ADDR_LOWER, AWD_ADDR_UPPER, AWD_ADDR_CTRL, 8'h10};
  logic [7:0] corner [4] = '{8'h80, 8'h40, 8'h81, 8'h3F};
  always #4 clk = ~clk;
  awd_window_detector u_dut (.i_sys_clk(clk), .i_rst(rst), .i_sfr_addr(addr), .i_sfr_wr(wr),
    .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_conv_done(done),
    .i_conv_data(data), .o_window_flag(flag));
  awd_conv_model u_conv (.i_sys_clk(clk), .i_go(go), .i_val(val), .o_conv_done(done),
    .o_conv_data(data));
  task automatic report_and_stop();
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic chk_rdata(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: read data %h expected %h", $time, got, exp);
    end
  endtask : chk_rdata
  task automatic chk_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: window flag %b expected %b", $time, got, exp);
    end
  endtask : chk_flag
  task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    addr = a;
    wdata = v;
    wr = w;
    rd = ~w;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
  endtask : sfr
  // Nonblocking drive keeps the model from racing the bench on the shared falling edge.
  task automatic conv(input logic [7:0] v);
    @(negedge clk);
    go <= 1'b1;
    val <= v;
    @(negedge clk);
    go <= 1'b0;
    @(negedge clk);
  endtask : conv
  // Puts a register write in the very cycle in which the converter result is taken.
  task automatic conv_wr(input logic [7:0] v, input logic [7:0] a, input logic [7:0] w);
    @(negedge clk);
    go <= 1'b1;
    val <= v;
    @(negedge clk);
    go <= 1'b0;
    addr = a;
    wdata = w;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : conv_wr
  function automatic logic exp_flag(input logic [7:0] v, input logic [7:0] hi, input logic [7:0] lo);
    return (v > hi) || (v < lo);
  endfunction : exp_flag
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      sfr(1'b0, amap[i], 8'h00);
      chk_rdata(rdata, 8'h00);
    end
    chk_flag(flag, 1'b0);
    for (int i = 0; i < 40; i++)
    begin
      t = 8'($random(seed));
      d = 8'($random(seed));
      u = (i < 4) ? 8'h80 : ((t > d) ? t : d);
      l = (i < 4) ? 8'h40 : ((t > d) ? d : t);
      d = (i < 4) ? corner[i] : 8'($random(seed));
      e = exp_flag(d, u, l);
      sfr(1'b1, AWD_ADDR_UPPER, u);
      sfr(1'b1, AWD_ADDR_LOWER, l);
      sfr(1'b0, AWD_ADDR_LOWER, 8'h00);
      chk_rdata(rdata, l);
      sfr(1'b0, AWD_ADDR_UPPER, 8'h00);
      chk_rdata(rdata, u);
      sfr(1'b1, AWD_ADDR_CTRL, 8'h00);
      chk_flag(flag, 1'b0);
      conv(d);
      chk_flag(flag, e);
      conv(l);
      chk_flag(flag, e);
      sfr(1'b0, AWD_ADDR_RESULT, 8'h00);
      chk_rdata(rdata, l);
      sfr(1'b0, AWD_ADDR_CTRL, 8'h00);
      chk_rdata(rdata, {5'h00, e, 2'h0});
      sfr(1'b1, 8'h10, d);
      sfr(1'b0, 8'h10, 8'h00);
      chk_rdata(rdata, 8'h00);
    end
    sfr(1'b1, AWD_ADDR_UPPER, 8'h20);
    sfr(1'b1, AWD_ADDR_LOWER, 8'h10);
    sfr(1'b1, AWD_ADDR_CTRL, 8'hFB);
    sfr(1'b1, AWD_ADDR_CTRL, 8'hFF);
    chk_flag(flag, 1'b0);
    conv(8'h30);
    chk_flag(flag, 1'b1);
    sfr(1'b1, AWD_ADDR_CTRL, 8'hFF);
    chk_flag(flag, 1'b1);
    sfr(1'b0, AWD_ADDR_CTRL, 8'h00);
    chk_rdata(rdata, 8'hFF);
    conv_wr(8'h05, AWD_ADDR_CTRL, 8'h00);
    chk_flag(flag, 1'b1);
    sfr(1'b1, AWD_ADDR_CTRL, 8'h00);
    chk_flag(flag, 1'b0);
    conv_wr(8'h18, AWD_ADDR_RESULT, 8'hAA);
    sfr(1'b0, AWD_ADDR_RESULT, 8'h00);
    chk_rdata(rdata, 8'h18);
    sfr(1'b1, AWD_ADDR_RESULT, 8'h5A);
    sfr(1'b0, AWD_ADDR_RESULT, 8'h00);
    chk_rdata(rdata, 8'h5A);
    chk_flag(flag, 1'b0);
    conv(8'h30);
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    chk_flag(flag, 1'b0);
    sfr(1'b0, AWD_ADDR_LOWER, 8'h00);
    chk_rdata(rdata, 8'h00);
    report_and_stop();
  end
endmodule : awd_window_detector_bench
`default_nettype wire
